// *** adcrw_cpu_model.sv ***
// Purpose: cpu-side master of the converter register port
// Assumes: one-cycle strobes, read data in the cycle after the read strobe
// Notes: every request changes just after a rising edge by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none

module adcrw_cpu_model
  import adcrw_pkg::*;
(
  input wire logic CLOCK,
  output var adcrw_bus_t BUS,
  input wire logic [7:0] BUS_RDATA
);
  // ----------------------------------------------------------------
  // bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    BUS = '0;
  end

  // one write strobe beside address and data
  task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    BUS <= {a, d, 1'b1, 1'b0};
    @(posedge CLOCK);
    BUS.wr <= 1'b0;
  endtask

  // one read strobe; answer taken in the following cycle only
  task automatic read_byte(input logic [4:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    BUS <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge CLOCK);
    BUS.rd <= 1'b0;
    #1;
    d = BUS_RDATA;
  endtask

  // high byte into the shared latch first, low byte commits both
  task automatic write_word(input logic [4:0] a, input logic [15:0] v);
    write_byte(a + ADCRW_OFS_HI_BYTE, v[15:8]);
    write_byte(a, v[7:0]);
  endtask
endmodule

`default_nettype wire

// *** adcrw_pkg.sv ***
// Purpose: constants, modes and carrier types of the converter result and window registers
// Assumes: byte-wide register port, 5-bit byte address, one clock
// Notes: sixteen-bit registers are two bytes, low byte at the even offset
`default_nettype none
package adcrw_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADCRW_OFS_MASK = 5'h0A; // interrupt mask
  localparam logic [4:0] ADCRW_OFS_STATUS = 5'h0B; // sticky event flags
  localparam logic [4:0] ADCRW_OFS_DEBUG = 5'h0C; // debug run control
  localparam logic [4:0] ADCRW_OFS_LATCH = 5'h0D; // shared byte latch
  localparam logic [4:0] ADCRW_OFS_CONV = 5'h10; // conversion value, read only
  localparam logic [4:0] ADCRW_OFS_WINLO = 5'h12; // window low limit
  localparam logic [4:0] ADCRW_OFS_WINHI = 5'h14; // window high limit
  localparam logic [4:0] ADCRW_OFS_HI_BYTE = 5'h01; // high byte distance from base

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ADCRW_BIT_DONE = 0; // conversion done flag
  localparam int ADCRW_BIT_WIN = 1; // window match flag
  localparam int ADCRW_BIT_OVERRIDE = 0; // halt override in debug control

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCRW_RST_BYTE = 8'h00; // every byte register
  localparam logic [15:0] ADCRW_RST_WORD = 16'h0000; // every word register
  localparam logic [1:0] ADCRW_RST_FLAGS = 2'h0; // status and mask

  // ----------------------------------------------------------------
  // sample and accumulation limits
  // ----------------------------------------------------------------
  localparam logic [9:0] ADCRW_CODE_MAX = 10'h3FF; // input above reference
  localparam logic [9:0] ADCRW_CODE_MIN = 10'h000; // input below ground
  localparam logic [15:0] ADCRW_ACC_MAX = 16'hFFC0; // 64 saturated samples
  localparam logic [2:0] ADCRW_ACC_LOG2_MAX = 3'h6; // at most 64 samples

  // ----------------------------------------------------------------
  // window mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ADCRW_WIN_NONE = 3'h0; // comparator off
  localparam logic [2:0] ADCRW_WIN_BELOW = 3'h1; // value below low limit
  localparam logic [2:0] ADCRW_WIN_ABOVE = 3'h2; // value above high limit
  localparam logic [2:0] ADCRW_WIN_INSIDE = 3'h3; // low <= value <= high
  localparam logic [2:0] ADCRW_WIN_OUTSIDE = 3'h4; // value outside limits

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] addr; // byte address
    logic [7:0] wdata; // write byte
    logic wr; // write strobe
    logic rd; // read strobe
  } adcrw_bus_t;

  typedef struct packed {
    logic [9:0] code; // raw converter code
    logic over; // input above reference
    logic under; // input below ground
  } adcrw_sample_t;

  typedef struct packed {
    logic [1:0] mask; // interrupt mask
    logic [1:0] status; // sticky flags
    logic override; // halt override
    logic [7:0] latch; // shared byte latch
    logic [15:0] conv; // conversion value
    logic [15:0] winlo; // window low limit
    logic [15:0] winhi; // window high limit
    logic [15:0] acc; // running sum
    logic [6:0] acc_cnt; // samples summed so far
    logic [6:0] acc_target; // samples per result
    logic [7:0] rdata; // read answer
  } adcrw_state_t;

endpackage

`default_nettype wire

// *** adcrw_top.sv ***
// Purpose: result, accumulation, window limits and shared byte latch of the converter
// Assumes: one clock, byte register port with read data one cycle after the strobe
// Notes: one sticky flag pair with a mask drives a single level interrupt
`timescale 1ns/1ps
`default_nettype none

module adcrw_top
  import adcrw_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire adcrw_bus_t BUS,
  output logic [7:0] BUS_RDATA,
  input wire logic CONV_DONE,
  input wire adcrw_sample_t SAMPLE,
  input wire logic [2:0] ACC_LOG2,
  input wire logic [2:0] WINDOW_MODE_SELECT,
  input wire logic CPU_HALTED,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  // true when the address is the low byte of a word register
  function automatic logic is_word_low(input logic [4:0] a);
    is_word_low = (a == ADCRW_OFS_CONV) || (a == ADCRW_OFS_WINLO) ||
                  (a == ADCRW_OFS_WINHI);
  endfunction

  // true when the address is the high byte of a word register
  function automatic logic is_word_high(input logic [4:0] a);
    is_word_high = is_word_low(5'(a - ADCRW_OFS_HI_BYTE));
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adcrw_state_t s_q; // registered state
  adcrw_state_t s_d; // next state
  logic active; // conversion events accepted this cycle
  logic take_sample; // a conversion event is accepted
  logic [9:0] code_sat; // saturated sample code
  logic [15:0] acc_base; // sum before this sample
  logic [15:0] acc_sum; // sum including this sample
  logic [6:0] cnt_next; // samples after this one
  logic [6:0] target_now; // samples per result for this run
  logic last_sample; // this sample ends the run
  logic win_match; // comparator answer on acc_sum
  logic [1:0] flag_set; // events this cycle
  logic [1:0] flag_clr; // software clears this cycle
  logic [2:0] log2_clamped; // log2 of accumulation depth, at most 6 (64 samples)
  logic [15:0] word_sel; // word register picked by the address

  // ----------------------------------------------------------------
  // debug halt gate
  // ----------------------------------------------------------------
  // halted cpu with override clear ignores conversion events; register access still runs
  assign active = !CPU_HALTED || s_q.override;
  assign take_sample = active && CONV_DONE;

  // ----------------------------------------------------------------
  // sample conditioning and accumulation
  // ----------------------------------------------------------------
  // over-range wins over under-range
  always_comb begin
    if (SAMPLE.over) begin
      code_sat = ADCRW_CODE_MAX;
    end else if (SAMPLE.under) begin
      code_sat = ADCRW_CODE_MIN;
    end else begin
      code_sat = SAMPLE.code;
    end
  end

  // depth is fixed at the first sample of a run
  assign log2_clamped = (ACC_LOG2 > ADCRW_ACC_LOG2_MAX) ? ADCRW_ACC_LOG2_MAX : ACC_LOG2;
  assign target_now = (s_q.acc_cnt == 7'h00) ? (7'h01 << log2_clamped) : s_q.acc_target;
  assign acc_base = (s_q.acc_cnt == 7'h00) ? ADCRW_RST_WORD : s_q.acc;
  // code lands in bits 9 to 0; 64 samples stay within 16 bits
  assign acc_sum = acc_base + {6'h00, code_sat};
  assign cnt_next = 7'(s_q.acc_cnt + 7'h01);
  assign last_sample = cnt_next == target_now;

  // ----------------------------------------------------------------
  // window comparator on the final sum
  // ----------------------------------------------------------------
  adcrw_window_cmp u_cmp (
    .value(acc_sum),
    .low_limit(s_q.winlo),
    .high_limit(s_q.winhi),
    .mode(WINDOW_MODE_SELECT),
    .match(win_match)
  );

  // ----------------------------------------------------------------
  // event and clear terms
  // ----------------------------------------------------------------
  // flags rise only when a run completes
  always_comb begin
    flag_set = 2'h0;
    if (take_sample && last_sample) begin
      flag_set[ADCRW_BIT_DONE] = 1'b1;
      flag_set[ADCRW_BIT_WIN] = win_match;
    end
  end

  // write one clears, reading the value low byte clears both
  always_comb begin
    flag_clr = 2'h0;
    if (BUS.wr && BUS.addr == ADCRW_OFS_STATUS) begin
      flag_clr = BUS.wdata[1:0];
    end else if (BUS.rd && BUS.addr == ADCRW_OFS_CONV) begin
      flag_clr = 2'h3;
    end
  end

  // word register behind a low byte address, zero for any other address
  always_comb begin
    word_sel = ADCRW_RST_WORD;
    if (BUS.addr == ADCRW_OFS_CONV) begin
      word_sel = s_q.conv;
    end else if (BUS.addr == ADCRW_OFS_WINLO) begin
      word_sel = s_q.winlo;
    end else if (BUS.addr == ADCRW_OFS_WINHI) begin
      word_sel = s_q.winhi;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = ADCRW_RST_BYTE; // answer stands one cycle only
    // accumulate an accepted sample
    if (take_sample) begin
      if (last_sample) begin
        s_d.conv = acc_sum;
        s_d.acc_cnt = 7'h00;
      end else begin
        s_d.acc = acc_sum;
        s_d.acc_cnt = cnt_next;
        s_d.acc_target = target_now;
      end
    end
    // register reads
    if (BUS.rd) begin
      if (BUS.addr == ADCRW_OFS_MASK) begin
        s_d.rdata = {6'h00, s_q.mask};
      end else if (BUS.addr == ADCRW_OFS_STATUS) begin
        s_d.rdata = {6'h00, s_q.status};
      end else if (BUS.addr == ADCRW_OFS_DEBUG) begin
        s_d.rdata = {7'h00, s_q.override};
      end else if (BUS.addr == ADCRW_OFS_LATCH) begin
        s_d.rdata = s_q.latch;
      end else if (is_word_low(BUS.addr)) begin
        s_d.rdata = word_sel[7:0];
        s_d.latch = word_sel[15:8];
      end else if (is_word_high(BUS.addr)) begin
        s_d.rdata = s_q.latch;
      end
    end
    // register writes
    if (BUS.wr) begin
      if (BUS.addr == ADCRW_OFS_MASK) begin
        s_d.mask = BUS.wdata[1:0];
      end else if (BUS.addr == ADCRW_OFS_DEBUG) begin
        s_d.override = BUS.wdata[ADCRW_BIT_OVERRIDE];
      end else if (BUS.addr == ADCRW_OFS_LATCH) begin
        s_d.latch = BUS.wdata;
      end else if (BUS.addr == ADCRW_OFS_WINLO) begin
        s_d.winlo = {s_q.latch, BUS.wdata};
      end else if (BUS.addr == ADCRW_OFS_WINHI) begin
        s_d.winhi = {s_q.latch, BUS.wdata};
      end else if (is_word_high(BUS.addr) && BUS.addr != 5'(ADCRW_OFS_CONV + ADCRW_OFS_HI_BYTE)) begin
        s_d.latch = BUS.wdata;
      end
      // conversion value bytes ignore writes
    end
    // an event in the clearing cycle survives
    s_d.status = (s_q.status & ~flag_clr) | flag_set;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q <= '{
        mask: ADCRW_RST_FLAGS,
        status: ADCRW_RST_FLAGS,
        override: 1'b0,
        latch: ADCRW_RST_BYTE,
        conv: ADCRW_RST_WORD,
        winlo: ADCRW_RST_WORD,
        winhi: ADCRW_RST_WORD,
        acc: ADCRW_RST_WORD,
        acc_cnt: 7'h00,
        acc_target: 7'h01,
        rdata: ADCRW_RST_BYTE
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign BUS_RDATA = s_q.rdata; // registered answer
  assign IRQ = |(s_q.status & s_q.mask); // level while unmasked flag set

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_halt_ignores;
    @(posedge CLOCK) disable iff (SYS_RST)
      (CPU_HALTED && !s_q.override && CONV_DONE) |=>
        $stable(s_q.acc_cnt) && $stable(s_q.conv) && $stable(s_q.acc);
  endproperty
  a_halt_ignores: assert property (p_halt_ignores)
    else $error("event taken while halted without override");

  property p_override_runs;
    @(posedge CLOCK) disable iff (SYS_RST)
      (CPU_HALTED && s_q.override && CONV_DONE && s_q.acc_cnt == 7'h00 &&
       ACC_LOG2 == 3'h0) |=> s_q.status[ADCRW_BIT_DONE];
  endproperty
  a_override_runs: assert property (p_override_runs)
    else $error("override set but conversion not completed in halt");

  property p_low_read_latches;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.rd && is_word_low(BUS.addr)) |=> {s_q.latch, BUS_RDATA} == $past(word_sel);
  endproperty
  a_low_read_latches: assert property (p_low_read_latches)
    else $error("low byte read did not latch high byte");

  property p_word_commit;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.wr && BUS.addr == ADCRW_OFS_WINLO) |=>
        s_q.winlo == {$past(s_q.latch), $past(BUS.wdata)};
  endproperty
  a_word_commit: assert property (p_word_commit)
    else $error("low limit not committed with latch byte");

  property p_saturate_high;
    @(posedge CLOCK) disable iff (SYS_RST)
      (take_sample && SAMPLE.over && s_q.acc_cnt == 7'h00 && ACC_LOG2 == 3'h0) |=>
        s_q.conv == {6'h00, ADCRW_CODE_MAX};
  endproperty
  a_saturate_high: assert property (p_saturate_high)
    else $error("over-range sample not saturated");

  property p_saturate_low;
    @(posedge CLOCK) disable iff (SYS_RST)
      (take_sample && SAMPLE.under && !SAMPLE.over && s_q.acc_cnt == 7'h00 &&
       ACC_LOG2 == 3'h0) |=> s_q.conv == ADCRW_RST_WORD;
  endproperty
  a_saturate_low: assert property (p_saturate_low)
    else $error("under-range sample not zero");

  property p_acc_bound;
    @(posedge CLOCK) disable iff (SYS_RST)
      (s_q.conv <= ADCRW_ACC_MAX) && (s_q.acc_cnt < 7'h40);
  endproperty
  a_acc_bound: assert property (p_acc_bound)
    else $error("accumulated value beyond bound");

  property p_read_clears;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.rd && BUS.addr == ADCRW_OFS_CONV && !take_sample) |=>
        s_q.status == 2'h0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("value read did not clear flags");

  property p_value_read_only;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.wr && !take_sample) |=> $stable(s_q.conv);
  endproperty
  a_value_read_only: assert property (p_value_read_only)
    else $error("conversion value changed by a write");

  property p_window_flag;
    @(posedge CLOCK) disable iff (SYS_RST)
      (take_sample && !last_sample && !s_q.status[ADCRW_BIT_WIN]) |=>
        !s_q.status[ADCRW_BIT_WIN];
  endproperty
  a_window_flag: assert property (p_window_flag)
    else $error("window flag set on a partial sum");

  // writing zeros to the status byte keeps set flags
  property p_zero_write_keeps;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.wr && BUS.addr == ADCRW_OFS_STATUS && BUS.wdata[1:0] == 2'h0 &&
       s_q.status != 2'h0) |=> s_q.status != 2'h0;
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("zero write cleared a status flag");

  // a direct write loads the shared latch
  property p_latch_write;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.wr && BUS.addr == ADCRW_OFS_LATCH) |=> s_q.latch == $past(BUS.wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch write not taken");

  // writes to the read-only high byte leave the latch alone
  property p_conv_high_ignored;
    @(posedge CLOCK) disable iff (SYS_RST)
      (BUS.wr && BUS.addr == 5'(ADCRW_OFS_CONV + ADCRW_OFS_HI_BYTE)) |=> $stable(s_q.latch);
  endproperty
  a_conv_high_ignored: assert property (p_conv_high_ignored)
    else $error("read-only high byte write reached the latch");

  // read answer stands for one cycle only, zero otherwise
  property p_answer_one_cycle;
    @(posedge CLOCK) disable iff (SYS_RST)
      !BUS.rd |=> BUS_RDATA == 8'h00;
  endproperty
  a_answer_one_cycle: assert property (p_answer_one_cycle)
    else $error("read answer outside its cycle");

endmodule

`default_nettype wire

// *** adcrw_window_cmp.sv ***
// Purpose: digital window comparator on the final converter value
// Assumes: unsigned values, limits as software wrote them
// Notes: purely combinational; the caller decides when the answer counts
`timescale 1ns/1ps
`default_nettype none

module adcrw_window_cmp
  import adcrw_pkg::*;
(
  input wire logic [15:0] value,
  input wire logic [15:0] low_limit,
  input wire logic [15:0] high_limit,
  input wire logic [2:0] mode,
  output logic match
);

  // ----------------------------------------------------------------
  // comparison per mode
  // ----------------------------------------------------------------
  logic below; // strictly under low limit
  logic above; // strictly over high limit

  // plain magnitude compare, all zeros is zero
  assign below = value < low_limit;
  assign above = value > high_limit;

  // pick the relation that the mode selects
  always_comb begin
    match = 1'b0;
    unique case (mode)
      ADCRW_WIN_NONE: match = 1'b0; // comparator off
      ADCRW_WIN_BELOW: match = below;
      ADCRW_WIN_ABOVE: match = above;
      ADCRW_WIN_INSIDE: match = !below && !above;
      ADCRW_WIN_OUTSIDE: match = below || above;
      default: match = 1'b0; // unused codes never match
    endcase
  end

endmodule

`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the converter result and window registers
// Assumes: cpu model drives the register port, bench drives conversion events
// Notes: each scenario judges its own results before it returns
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module tb;
  import adcrw_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 1'b0; // 200 MHz
  logic sys_rst = 1'b1; // held for 20 cycles
  adcrw_bus_t bus; // from the cpu model
  logic [7:0] bus_rdata;
  logic conv_done = 1'b0;
  adcrw_sample_t sample = '0;
  logic [2:0] acc_log2 = 3'h0;
  logic [2:0] win_mode = 3'h0;
  logic cpu_halted = 1'b0;
  logic irq;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  adcrw_top adcrw_top_inst (.CLOCK(clock), .SYS_RST(sys_rst), .BUS(bus), .BUS_RDATA(bus_rdata),
    .CONV_DONE(conv_done), .SAMPLE(sample), .ACC_LOG2(acc_log2),
    .WINDOW_MODE_SELECT(win_mode), .CPU_HALTED(cpu_halted), .IRQ(irq));
  adcrw_cpu_model adcrw_cpu_model_inst (.CLOCK(clock), .BUS(bus), .BUS_RDATA(bus_rdata));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    adcrw_cpu_model_inst.write_byte(a, d);
  endtask

  task automatic ww(input logic [4:0] a, input logic [15:0] v);
    adcrw_cpu_model_inst.write_word(a, v);
  endtask

  // read one byte and compare
  task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    adcrw_cpu_model_inst.read_byte(a, d);
    `CHK($sformatf("reg %0h", a), e, d)
  endtask

  task automatic chk_irq(input logic e);
    #1;
    `CHK("irq", e, irq)
  endtask

  // n back-to-back samples, then one idle edge for the result
  task automatic conv(input int n, input adcrw_sample_t s);
    repeat (n) begin
      @(posedge clock);
      conv_done <= 1'b1;
      sample <= s;
    end
    @(posedge clock);
    conv_done <= 1'b0;
    @(posedge clock);
  endtask

  // window answer for limits 0x0100 and 0x0200
  function automatic logic win_exp(input logic [2:0] m, input logic [15:0] v);
    case (m)
      ADCRW_WIN_BELOW: return v < 16'h0100;
      ADCRW_WIN_ABOVE: return v > 16'h0200;
      ADCRW_WIN_INSIDE: return v >= 16'h0100 && v <= 16'h0200;
      ADCRW_WIN_OUTSIDE: return v < 16'h0100 || v > 16'h0200;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 10; i < 22; i++) begin
      chk_reg(5'(i), 8'h00);
    end
    chk_reg(5'h1F, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_word();
    ww(ADCRW_OFS_WINLO, 16'h1234);
    chk_reg(ADCRW_OFS_LATCH, 8'h12);
    wr(ADCRW_OFS_LATCH, 8'hA5);
    chk_reg(ADCRW_OFS_WINLO + 5'h01, 8'hA5);
    chk_reg(ADCRW_OFS_WINLO, 8'h34);
    chk_reg(ADCRW_OFS_WINLO + 5'h01, 8'h12);
    wr(ADCRW_OFS_WINHI + 5'h01, 8'h77);
    chk_reg(ADCRW_OFS_WINHI, 8'h00);
    wr(ADCRW_OFS_WINHI + 5'h01, 8'h77);
    wr(ADCRW_OFS_WINHI, 8'h66);
    chk_reg(ADCRW_OFS_WINHI, 8'h66);
    chk_reg(ADCRW_OFS_WINHI + 5'h01, 8'h77);
    wr(ADCRW_OFS_CONV + 5'h01, 8'h55);
    chk_reg(ADCRW_OFS_LATCH, 8'h77);
    wr(ADCRW_OFS_CONV, 8'hAA);
    chk_reg(ADCRW_OFS_CONV, 8'h00);
    $display("test word access done");
  endtask

  task automatic t_single();
    wr(ADCRW_OFS_MASK, 8'h01);
    conv(1, {10'h155, 1'b0, 1'b0});
    chk_reg(ADCRW_OFS_STATUS, 8'h01);
    chk_irq(1'b1);
    wr(ADCRW_OFS_STATUS, 8'h00);
    chk_reg(ADCRW_OFS_STATUS, 8'h01);
    wr(ADCRW_OFS_MASK, 8'h00);
    chk_irq(1'b0);
    wr(ADCRW_OFS_STATUS, 8'h01);
    chk_reg(ADCRW_OFS_STATUS, 8'h00);
    chk_reg(ADCRW_OFS_CONV, 8'h55);
    chk_reg(ADCRW_OFS_CONV + 5'h01, 8'h01);
    conv(1, {10'h000, 1'b1, 1'b0});
    chk_reg(ADCRW_OFS_CONV, 8'hFF);
    chk_reg(ADCRW_OFS_CONV + 5'h01, 8'h03);
    chk_reg(ADCRW_OFS_STATUS, 8'h00);
    conv(1, {10'h3FF, 1'b0, 1'b1});
    chk_reg(ADCRW_OFS_CONV, 8'h00);
    chk_reg(ADCRW_OFS_CONV + 5'h01, 8'h00);
    $display("test single sample done");
  endtask

  task automatic t_accum();
    ww(ADCRW_OFS_WINHI, 16'h8000);
    wr(ADCRW_OFS_MASK, 8'h02);
    @(posedge clock);
    acc_log2 <= 3'h6;
    win_mode <= ADCRW_WIN_ABOVE;
    conv(63, {10'h000, 1'b1, 1'b0});
    chk_reg(ADCRW_OFS_STATUS, 8'h00);
    conv(1, {10'h000, 1'b1, 1'b0});
    chk_reg(ADCRW_OFS_STATUS, 8'h03);
    chk_irq(1'b1);
    wr(ADCRW_OFS_STATUS, 8'h02);
    chk_reg(ADCRW_OFS_STATUS, 8'h01);
    chk_irq(1'b0);
    chk_reg(ADCRW_OFS_CONV, 8'hC0);
    chk_reg(ADCRW_OFS_CONV + 5'h01, 8'hFF);
    $display("test accumulation done");
  endtask

  task automatic t_modes();
    logic [15:0] vals [4] = '{16'h00FF, 16'h0100, 16'h0200, 16'h0201};
    logic e;
    ww(ADCRW_OFS_WINLO, 16'h0100);
    ww(ADCRW_OFS_WINHI, 16'h0200);
    @(posedge clock);
    acc_log2 <= 3'h0;
    for (int m = 0; m < 6; m++) begin
      for (int i = 0; i < 4; i++) begin
        @(posedge clock);
        win_mode <= 3'(m);
        e = win_exp(3'(m), vals[i]);
        conv(1, {vals[i][9:0], 1'b0, 1'b0});
        chk_reg(ADCRW_OFS_STATUS, {6'h00, e, 1'b1});
        chk_reg(ADCRW_OFS_CONV, vals[i][7:0]);
      end
    end
    chk_reg(ADCRW_OFS_STATUS, 8'h00);
    $display("test window modes done");
  endtask

  task automatic t_halt();
    @(posedge clock);
    cpu_halted <= 1'b1;
    conv(1, {10'h2AA, 1'b0, 1'b0});
    chk_reg(ADCRW_OFS_STATUS, 8'h00);
    chk_reg(ADCRW_OFS_CONV, 8'h01);
    wr(ADCRW_OFS_DEBUG, 8'h01);
    chk_reg(ADCRW_OFS_DEBUG, 8'h01);
    conv(1, {10'h2AA, 1'b0, 1'b0});
    chk_reg(ADCRW_OFS_STATUS, 8'h01);
    chk_reg(ADCRW_OFS_CONV, 8'hAA);
    @(posedge clock);
    cpu_halted <= 1'b0;
    $display("test debug halt done");
  endtask

  // ----------------------------------------------------------------
  // verdict, timeout and main sequence
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard well above the few hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_word();
    t_single();
    t_accum();
    t_modes();
    t_halt();
    finish_test();
  end
endmodule

`default_nettype wire
